// >>> rtl/mat_core.sv
`timescale 1ns/1ns
module mat_core
    import mat_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        issue_valid,
    output logic             issue_ready,
    input  wire logic [7:0]  issue_opcode,
    input  wire logic [7:0]  issue_arg1,
    input  wire logic [7:0]  issue_arg2,
    input  wire logic [1:0]  bank_sel,
    input  wire logic        data_pointer_load,
    input  wire logic [15:0] data_pointer_value,
    input  wire logic        b_load,
    input  wire logic [7:0]  b_value,
    output logic             retire,
    output logic             retire_illegal,
    output logic [1:0]       retire_bytes,
    output logic [3:0]       retire_cycles,
    output logic [7:0]       acc,
    output logic [7:0]       b_reg,
    output logic             carry,
    output logic             aux_carry,
    output logic             overflow,
    output logic [15:0]      data_pointer,
    output logic [7:0]       iram_addr,
    output logic [7:0]       iram_wdata,
    output logic             iram_we,
    input  wire logic [7:0]  iram_rdata,
    output logic [7:0]       func_reg_addr,
    output logic [7:0]       func_reg_wdata,
    output logic             func_reg_we,
    output logic             func_reg_re,
    input  wire logic [7:0]  func_reg_rdata,
    output logic [15:0]      code_addr,
    output logic             code_re,
    input  wire logic [7:0]  code_rdata
);

    function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
        return {BANK_PAD, bank, idx};
    endfunction : bank_addr

    // Returns {carry, aux carry, overflow, result}
    function automatic logic [10:0] add_sub(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic sub);
        logic [7:0] bb;
        logic       ci;
        logic [8:0] full;
        logic [4:0] half;
        logic       ov;
        bb   = sub ? ~b : b;
        ci   = sub ? ~cin : cin;
        full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        ov   = (a[7] == bb[7]) && (full[7] != a[7]);
        return {full[8] ^ sub, half[4] ^ sub, ov, full[7:0]};
    endfunction : add_sub

    mat_state_t  state_q;
    logic [3:0]  cnt_q;
    logic [7:0]  opc_q;
    logic [7:0]  arg1_q;
    logic [7:0]  arg2_q;
    mat_dec_t    dec_q;
    mat_dec_t    dec_now;
    logic [7:0]  ptr_q;
    logic [7:0]  acc_q;
    logic [7:0]  acc_d;
    logic [7:0]  b_q;
    logic [7:0]  b_d;
    logic        c_q;
    logic        c_d;
    logic        ac_q;
    logic        ac_d;
    logic        ov_q;
    logic        ov_d;
    logic [15:0] dp_q;
    logic [15:0] dp_d;
    logic        retire_q;
    logic        illegal_q;
    logic [1:0]  bytes_q;
    logic [3:0]  cycles_q;

    logic        last;
    logic        take;
    logic        ptr_phase;
    logic [7:0]  opnd_addr;
    logic        opnd_is_func;
    logic [7:0]  mem_byte;
    logic [7:0]  src_b;
    logic [7:0]  lhs;
    logic [7:0]  rhs;
    logic [7:0]  res_v;
    logic [10:0] as_v;
    logic [15:0] prod_v;
    logic [8:0]  adj_v;
    logic        mem_we;
    logic        ext_we;
    logic [7:0]  ext_addr;
    logic [7:0]  ext_rdata;

    assign dec_now     = mat_decode(issue_opcode);
    assign last        = (state_q == ST_BUSY) && ((cnt_q + CNT_STEP) == dec_q.cyc);
    // Ready in the final cycle lets one-cycle instructions retire back to back
    assign issue_ready = (state_q == ST_IDLE) || last;
    assign take        = issue_valid && issue_ready;
    assign ptr_phase   = (state_q == ST_BUSY) && (cnt_q == CNT_ZERO) && (dec_q.mode == MD_IND);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
            opc_q   <= 8'h00;
            arg1_q  <= 8'h00;
            arg2_q  <= 8'h00;
            dec_q   <= '{OP_ILLEGAL, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
        end else if (take) begin
            state_q <= ST_BUSY;
            cnt_q   <= CNT_ZERO;
            opc_q   <= issue_opcode;
            arg1_q  <= issue_arg1;
            arg2_q  <= issue_arg2;
            dec_q   <= dec_now;
        end else if (last) begin
            state_q <= ST_IDLE;
        end else if (state_q == ST_BUSY) begin
            cnt_q <= cnt_q + CNT_STEP;
        end
    end

    // Pointer register is read one cycle ahead of the indirect access
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= 8'h00;
        end else if (ptr_phase) begin
            ptr_q <= iram_rdata;
        end
    end

    always_comb begin
        unique case (dec_q.mode)
            MD_REG:  opnd_addr = bank_addr(bank_sel, opc_q[2:0]);
            MD_IND:  opnd_addr = ptr_q;
            MD_DIR:  opnd_addr = arg1_q;
            default: opnd_addr = 8'h00;
        endcase
    end

    // Only direct mode ever leaves internal RAM; indirect stays in RAM for the upper half
    assign opnd_is_func   = (dec_q.mode == MD_DIR) && (arg1_q >= DIR_FUNC_BASE);
    assign iram_addr      = ptr_phase ? bank_addr(bank_sel, {2'h0, opc_q[0]}) : opnd_addr;
    assign func_reg_addr  = arg1_q;
    assign func_reg_re    = last && opnd_is_func;
    assign mem_byte       = opnd_is_func ? func_reg_rdata : iram_rdata;
    assign src_b          = (dec_q.mode == MD_IMM) ? arg1_q : mem_byte;
    assign lhs            = dec_q.to_mem ? mem_byte : acc_q;
    assign rhs            = dec_q.to_mem ? ((opc_q[3:0] == LO_DIR_IMM) ? arg2_q : acc_q) : src_b;

    assign mem_we         = last && dec_q.to_mem && (dec_q.op != OP_ILLEGAL);
    assign iram_we        = mem_we && !opnd_is_func;
    assign func_reg_we    = mem_we && opnd_is_func;
    assign iram_wdata     = res_v;
    assign func_reg_wdata = res_v;

    // Upper byte of the data pointer is ignored: the extended space is eight bits wide
    assign ext_addr = (dec_q.mode == MD_IND) ? ptr_q : dp_q[7:0];
    assign ext_we   = last && (dec_q.op == OP_EXT_WR);

    // Extended moves stay on chip; no external bus port exists
    mat_ext_ram u_ext_ram (
        .clock (clock),
        .wr_en (ext_we),
        .addr  (ext_addr),
        .wdata (acc_q),
        .rdata (ext_rdata)
    );

    assign code_addr = dp_q + {8'h00, acc_q};
    assign code_re   = last && (dec_q.op == OP_CODE_RD);

    always_comb begin
        res_v  = lhs;
        as_v   = add_sub(lhs, rhs, c_q, 1'b0);
        prod_v = acc_q * b_q;
        adj_v  = {1'b0, acc_q};
        acc_d  = acc_q;
        b_d    = b_q;
        c_d    = c_q;
        ac_d   = ac_q;
        ov_d   = ov_q;
        dp_d   = dp_q;
        unique case (dec_q.op)
            OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW: begin
                as_v  = add_sub(lhs, rhs, (dec_q.op != OP_ADD) && c_q,
                                dec_q.op == OP_SUB_BORROW);
                res_v = as_v[7:0];
                c_d   = as_v[10];
                ac_d  = as_v[9];
                ov_d  = as_v[8];
                acc_d = res_v;
            end
            OP_OR: begin
                res_v = lhs | rhs;
                acc_d = dec_q.to_mem ? acc_q : res_v;
            end
            OP_AND: begin
                res_v = lhs & rhs;
                acc_d = dec_q.to_mem ? acc_q : res_v;
            end
            OP_XOR: begin
                res_v = lhs ^ rhs;
                acc_d = dec_q.to_mem ? acc_q : res_v;
            end
            OP_MOV_ACC: acc_d = src_b;
            OP_INC: begin
                res_v = lhs + 8'h01;
                acc_d = dec_q.to_mem ? acc_q : res_v;
            end
            OP_DEC: begin
                res_v = lhs - 8'h01;
                acc_d = dec_q.to_mem ? acc_q : res_v;
            end
            OP_INC_DP: dp_d = dp_q + 16'h0001;
            OP_MUL: begin
                acc_d = prod_v[7:0];
                b_d   = prod_v[15:8];
                c_d   = 1'b0;
                ov_d  = |prod_v[15:8];
            end
            OP_QUOT: begin
                c_d  = 1'b0;
                // Divide by zero flags overflow and leaves both operands untouched
                ov_d = (b_q == 8'h00);
                if (b_q != 8'h00) begin
                    acc_d = acc_q / b_q;
                    b_d   = acc_q % b_q;
                end
            end
            OP_DEC_ADJ: begin
                if ((acc_q[3:0] > ADJ_LIMIT) || ac_q) begin
                    adj_v = {1'b0, acc_q} + {1'b0, ADJ_LO_STEP};
                end
                c_d = c_q | adj_v[8];
                if ((adj_v[7:4] > ADJ_LIMIT) || c_d) begin
                    adj_v = {1'b0, adj_v[7:0]} + {1'b0, ADJ_HI_STEP};
                    c_d   = c_d | adj_v[8];
                end
                acc_d = adj_v[7:0];
            end
            OP_CLEAR:    acc_d = 8'h00;
            OP_INVERT:   acc_d = ~acc_q;
            OP_SWAP:     acc_d = {acc_q[3:0], acc_q[7:4]};
            OP_ROT_LEFT: acc_d = {acc_q[6:0], acc_q[7]};
            OP_EXT_RD:   acc_d = ext_rdata;
            OP_EXT_WR:   acc_d = acc_q;
            OP_CODE_RD:  acc_d = code_rdata;
            OP_ILLEGAL:  acc_d = acc_q;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= 8'h00;
            c_q   <= 1'b0;
            ac_q  <= 1'b0;
            ov_q  <= 1'b0;
        end else if (last) begin
            acc_q <= acc_d;
            c_q   <= c_d;
            ac_q  <= ac_d;
            ov_q  <= ov_d;
        end
    end

    // Side loads yield to an instruction that writes the same register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            b_q <= 8'h00;
        end else if (last && (dec_q.op == OP_MUL || dec_q.op == OP_QUOT)) begin
            b_q <= b_d;
        end else if (b_load) begin
            b_q <= b_value;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dp_q <= 16'h0000;
        end else if (last && dec_q.op == OP_INC_DP) begin
            dp_q <= dp_d;
        end else if (data_pointer_load) begin
            dp_q <= data_pointer_value;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            retire_q  <= 1'b0;
            illegal_q <= 1'b0;
            bytes_q   <= 2'h0;
            cycles_q  <= 4'h0;
        end else begin
            retire_q  <= last;
            illegal_q <= last && (dec_q.op == OP_ILLEGAL);
            if (last) begin
                bytes_q  <= dec_q.len;
                cycles_q <= dec_q.cyc;
            end
        end
    end

    assign retire         = retire_q;
    assign retire_illegal = illegal_q;
    assign retire_bytes   = bytes_q;
    assign retire_cycles  = cycles_q;
    assign acc            = acc_q;
    assign b_reg          = b_q;
    assign carry          = c_q;
    assign aux_carry      = ac_q;
    assign overflow       = ov_q;
    assign data_pointer   = dp_q;

endmodule : mat_core

// >>> rtl/mat_ext_ram.sv
`timescale 1ns/1ns
module mat_ext_ram
    import mat_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       wr_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);

    // Eight address bits cover every one of the locations
    logic [7:0] mem [EXT_RAM_DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];

endmodule : mat_ext_ram

// >>> rtl/mat_pkg.sv
package mat_pkg;

    localparam int          EXT_RAM_DEPTH = 256;
    localparam logic [7:0]  DIR_FUNC_BASE = 8'h80;
    localparam logic [2:0]  BANK_PAD      = 3'h0;
    localparam logic [3:0]  CNT_ZERO      = 4'h0;
    localparam logic [3:0]  CNT_STEP      = 4'h1;

    localparam logic [1:0]  LEN_ONE       = 2'h1;
    localparam logic [1:0]  LEN_TWO       = 2'h2;
    localparam logic [1:0]  LEN_THREE     = 2'h3;
    localparam logic [3:0]  CYC_ONE       = 4'h1;
    localparam logic [3:0]  CYC_TWO       = 4'h2;
    localparam logic [3:0]  CYC_THREE     = 4'h3;
    localparam logic [3:0]  CYC_FOUR      = 4'h4;
    localparam logic [3:0]  CYC_NINE      = 4'h9;

    localparam logic [7:0]  OPC_INC_DP    = 8'hA3;
    localparam logic [7:0]  OPC_MUL       = 8'hA4;
    localparam logic [7:0]  OPC_QUOT      = 8'h84;
    localparam logic [7:0]  OPC_DEC_ADJ   = 8'hD4;
    localparam logic [7:0]  OPC_CLEAR     = 8'hE4;
    localparam logic [7:0]  OPC_INVERT    = 8'hF4;
    localparam logic [7:0]  OPC_SWAP      = 8'hC4;
    localparam logic [7:0]  OPC_ROT_LEFT  = 8'h23;
    localparam logic [7:0]  OPC_EXT_RD_DP = 8'hE0;
    localparam logic [7:0]  OPC_EXT_RD_P0 = 8'hE2;
    localparam logic [7:0]  OPC_EXT_RD_P1 = 8'hE3;
    localparam logic [7:0]  OPC_EXT_WR_DP = 8'hF0;
    localparam logic [7:0]  OPC_EXT_WR_P0 = 8'hF2;
    localparam logic [7:0]  OPC_EXT_WR_P1 = 8'hF3;
    localparam logic [7:0]  OPC_CODE_RD   = 8'h93;

    localparam logic [3:0]  HI_INC        = 4'h0;
    localparam logic [3:0]  HI_DEC        = 4'h1;
    localparam logic [3:0]  HI_ADD        = 4'h2;
    localparam logic [3:0]  HI_ADD_CARRY  = 4'h3;
    localparam logic [3:0]  HI_OR         = 4'h4;
    localparam logic [3:0]  HI_AND        = 4'h5;
    localparam logic [3:0]  HI_XOR        = 4'h6;
    localparam logic [3:0]  HI_SUB_BORROW = 4'h9;
    localparam logic [3:0]  HI_MOV_ACC    = 4'hE;
    localparam logic [3:0]  LO_DIR_ACC    = 4'h2;
    localparam logic [3:0]  LO_DIR_IMM    = 4'h3;
    localparam logic [3:0]  LO_IMM        = 4'h4;
    localparam logic [3:0]  LO_DIR        = 4'h5;
    localparam logic [2:0]  LO_IND_HI     = 3'h3;
    localparam logic [3:0]  LO_REG        = 4'h8;

    localparam logic [3:0]  ADJ_LIMIT     = 4'h9;
    localparam logic [7:0]  ADJ_LO_STEP   = 8'h06;
    localparam logic [7:0]  ADJ_HI_STEP   = 8'h60;

    typedef enum logic {ST_IDLE, ST_BUSY} mat_state_t;

    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW, OP_OR, OP_AND, OP_XOR, OP_MOV_ACC,
        OP_INC, OP_DEC, OP_INC_DP, OP_MUL, OP_QUOT, OP_DEC_ADJ, OP_CLEAR,
        OP_INVERT, OP_SWAP, OP_ROT_LEFT, OP_EXT_RD, OP_EXT_WR, OP_CODE_RD, OP_ILLEGAL
    } mat_op_t;

    typedef enum logic [2:0] {MD_NONE, MD_IMM, MD_DIR, MD_IND, MD_REG} mat_mode_t;

    typedef struct packed {
        mat_op_t     op;
        mat_mode_t   mode;
        logic        to_mem;
        logic [1:0]  len;
        logic [3:0]  cyc;
    } mat_dec_t;

    function automatic mat_dec_t mat_decode(input logic [7:0] opc);
        mat_dec_t   d;
        logic [3:0] lo;
        logic       ok;
        lo = opc[3:0];
        ok = 1'b1;
        d  = '{OP_ILLEGAL, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
        unique case (opc)
            OPC_INC_DP:    d = '{OP_INC_DP, MD_NONE, 1'b0, LEN_ONE, CYC_THREE};
            OPC_MUL:       d = '{OP_MUL, MD_NONE, 1'b0, LEN_ONE, CYC_NINE};
            OPC_QUOT:      d = '{OP_QUOT, MD_NONE, 1'b0, LEN_ONE, CYC_NINE};
            OPC_DEC_ADJ:   d = '{OP_DEC_ADJ, MD_NONE, 1'b0, LEN_ONE, CYC_TWO};
            OPC_CLEAR:     d = '{OP_CLEAR, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
            OPC_INVERT:    d = '{OP_INVERT, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
            OPC_SWAP:      d = '{OP_SWAP, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
            OPC_ROT_LEFT:  d = '{OP_ROT_LEFT, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
            OPC_EXT_RD_DP: d = '{OP_EXT_RD, MD_NONE, 1'b0, LEN_ONE, CYC_FOUR};
            OPC_EXT_WR_DP: d = '{OP_EXT_WR, MD_NONE, 1'b0, LEN_ONE, CYC_FOUR};
            OPC_EXT_RD_P0,
            OPC_EXT_RD_P1: d = '{OP_EXT_RD, MD_IND, 1'b0, LEN_ONE, CYC_FOUR};
            OPC_EXT_WR_P0,
            OPC_EXT_WR_P1: d = '{OP_EXT_WR, MD_IND, 1'b0, LEN_ONE, CYC_FOUR};
            OPC_CODE_RD:   d = '{OP_CODE_RD, MD_NONE, 1'b0, LEN_ONE, CYC_FOUR};
            default: begin
                // Operand form from the low nibble, shared by all groups; INC/DEC low nibble 4 selects the accumulator and XOR indirect is two bytes
                if (lo >= LO_REG) begin
                    d = '{OP_ILLEGAL, MD_REG, 1'b0, LEN_ONE, CYC_ONE};
                end else if (lo[3:1] == LO_IND_HI) begin
                    d = '{OP_ILLEGAL, MD_IND, 1'b0, LEN_ONE, CYC_TWO};
                end else if (lo == LO_DIR) begin
                    d = '{OP_ILLEGAL, MD_DIR, 1'b0, LEN_TWO, CYC_TWO};
                end else if (lo == LO_IMM) begin
                    d = '{OP_ILLEGAL, MD_IMM, 1'b0, LEN_TWO, CYC_TWO};
                end else if (lo == LO_DIR_ACC) begin
                    d = '{OP_ILLEGAL, MD_DIR, 1'b1, LEN_TWO, CYC_TWO};
                end else if (lo == LO_DIR_IMM) begin
                    d = '{OP_ILLEGAL, MD_DIR, 1'b1, LEN_THREE, CYC_THREE};
                end else begin
                    ok = 1'b0;
                end
                unique case (opc[7:4])
                    HI_INC, HI_DEC: begin
                        d.op = (opc[7:4] == HI_INC) ? OP_INC : OP_DEC;
                        ok   = ok && (lo >= LO_IMM);
                        if (lo == LO_IMM) begin
                            d = '{d.op, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
                        end else begin
                            d.to_mem = 1'b1;
                        end
                    end
                    HI_ADD:        d.op = OP_ADD;
                    HI_ADD_CARRY:  d.op = OP_ADD_CARRY;
                    HI_SUB_BORROW: d.op = OP_SUB_BORROW;
                    HI_MOV_ACC:    d.op = OP_MOV_ACC;
                    HI_OR:         d.op = OP_OR;
                    HI_AND:        d.op = OP_AND;
                    HI_XOR: begin
                        d.op = OP_XOR;
                        if (d.mode == MD_IND) begin
                            d.len = LEN_TWO;
                        end
                    end
                    default: ok = 1'b0;
                endcase
                if (opc[7:4] == HI_MOV_ACC) begin
                    ok = ok && (lo >= LO_DIR);
                end else if (opc[7:4] != HI_OR && opc[7:4] != HI_AND && opc[7:4] != HI_XOR) begin
                    ok = ok && (lo >= LO_IMM);
                end
                if (!ok) begin
                    d = '{OP_ILLEGAL, MD_NONE, 1'b0, LEN_ONE, CYC_ONE};
                end
            end
        endcase
        return d;
    endfunction : mat_decode

endpackage : mat_pkg

// >>> verif/mat_core_props.sv
`timescale 1ns/1ns
module mat_core_props (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        issue_valid,
    input wire logic        issue_ready,
    input wire logic [7:0]  issue_opcode,
    input wire logic        retire,
    input wire logic [1:0]  retire_bytes,
    input wire logic [3:0]  retire_cycles,
    input wire logic [7:0]  acc,
    input wire logic [15:0] data_pointer,
    input wire logic [7:0]  func_reg_addr,
    input wire logic        func_reg_re,
    input wire logic        func_reg_we,
    input wire logic        iram_we,
    input wire logic [15:0] code_addr,
    input wire logic        code_re
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire take = issue_valid && issue_ready;
    sequence s_fin(int c, int b);
        retire && retire_cycles == c && retire_bytes == b;
    endsequence
    a_clear_one_cyc: assert property (take && issue_opcode == 8'hE4 |-> ##2 s_fin(1, 1))
        else $error("clear timing");
    a_reg_add_one: assert property (take && issue_opcode[3] && issue_opcode[7:4] inside
        {4'h2, 4'h3, 4'h9} |-> ##2 s_fin(1, 1)) else $error("reg timing");
    a_ind_two_cyc: assert property (take && issue_opcode[7:1] inside {7'h13, 7'h1B, 7'h4B}
        |-> ##2 !retire ##1 s_fin(2, 1)) else $error("indirect timing");
    a_mul_nine_cyc: assert property (take && issue_opcode inside {8'hA4, 8'h84}
        |-> ##2 !retire [*8] ##1 s_fin(9, 1)) else $error("mul timing");
    a_mul_refuse: assert property (take && issue_opcode == 8'hA4
        |=> !issue_ready [*8] ##1 issue_ready) else $error("busy window");
    a_logic_dir_imm: assert property (take && issue_opcode inside {8'h43, 8'h53, 8'h63}
        |-> ##2 !retire [*2] ##1 s_fin(3, 3)) else $error("dir imm timing");
    a_ext_four_cyc: assert property (take && issue_opcode inside {8'hE0, 8'hE2, 8'hF0, 8'hF2}
        |-> ##2 !retire [*3] ##1 s_fin(4, 1)) else $error("ext timing");
    a_code_sum: assert property (code_re |-> code_addr == data_pointer + {8'h00, acc})
        else $error("code address");
    a_func_upper: assert property (func_reg_re |-> func_reg_addr >= 8'h80)
        else $error("register space hit");
    a_func_write_dir: assert property (func_reg_we |-> func_reg_addr >= 8'h80 && !iram_we)
        else $error("register write");
    a_dp_inc_three: assert property (take && issue_opcode == 8'hA3 |-> ##4 s_fin(3, 1) ##0
        data_pointer == $past(data_pointer, 4) + 16'h0001) else $error("pointer inc");
endmodule : mat_core_props
bind mat_core mat_core_props u_props (.clock, .reset_n, .issue_valid, .issue_ready,
    .issue_opcode, .retire, .retire_bytes, .retire_cycles, .acc, .data_pointer,
    .func_reg_addr, .func_reg_re, .func_reg_we, .iram_we, .code_addr, .code_re);

// >>> verif/mat_core_tb.sv
`timescale 1ns/1ns
module mat_core_tb;
    logic        clock, reset_n, issue_valid, issue_ready, data_pointer_load, b_load;
    logic        retire, retire_illegal, carry, aux_carry, overflow, iram_we, ill;
    logic [1:0]  bank_sel, retire_bytes;
    logic [3:0]  retire_cycles;
    logic [7:0]  issue_opcode, issue_arg1, issue_arg2, b_value, acc, b_reg;
    logic [7:0]  iram_addr, iram_wdata, iram_rdata, func_reg_addr, func_reg_rdata, code_rdata;
    logic [15:0] data_pointer_value, data_pointer, code_addr;
    int          n_errors, num_checks, n_cyc;
    mat_core dut (.clock, .reset_n, .issue_valid, .issue_ready, .issue_opcode, .issue_arg1,
        .issue_arg2, .bank_sel, .data_pointer_load, .data_pointer_value, .b_load, .b_value,
        .retire, .retire_illegal, .retire_bytes, .retire_cycles, .acc, .b_reg, .carry,
        .aux_carry, .overflow, .data_pointer, .iram_addr, .iram_wdata, .iram_we,
        .iram_rdata, .func_reg_addr, .func_reg_wdata(), .func_reg_we(), .func_reg_re(),
        .func_reg_rdata, .code_addr, .code_re(), .code_rdata);
    mat_mem_model mem (.clock, .iram_addr, .iram_wdata, .iram_we, .iram_rdata,
        .func_reg_addr, .func_reg_rdata, .code_addr, .code_rdata);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Waits on retire, counting cycles from the issue edge
    task automatic run(input logic [7:0] o, input logic [7:0] a1, input logic [7:0] a2);
        issue_opcode <= o;
        issue_arg1   <= a1;
        issue_arg2   <= a2;
        issue_valid  <= 1'b1;
        @(posedge clock);
        issue_valid <= 1'b0;
        n_cyc = -1;
        do begin
            @(negedge clock);
            n_cyc++;
        end while (retire !== 1'b1 && n_cyc < 20);
        ill = retire_illegal;
        @(posedge clock);
    endtask : run
    task automatic ld_side(input logic [15:0] d, input logic [7:0] bv);
        data_pointer_value <= d;
        b_value            <= bv;
        data_pointer_load  <= 1'b1;
        b_load             <= 1'b1;
        @(posedge clock);
        data_pointer_load <= 1'b0;
        b_load            <= 1'b0;
    endtask : ld_side
    task automatic ld_acc(input logic [7:0] v);
        run(8'hE4, 8'h00, 8'h00);
        run(8'h24, v, 8'h00);
    endtask : ld_acc
    task automatic t_addr;
        logic [31:0] tab [5] = '{32'h01E8_0088, 32'h01E6_0008, 32'h00E7_0021,
                                 32'h00E5_3585, 32'h00E5_906F};
        foreach (tab[i]) begin
            bank_sel <= tab[i][25:24];
            run(tab[i][23:16], tab[i][15:8], 8'h00);
            chk(acc, tab[i][7:0]);
        end
        // Direct write into the upper half must leave the RAM byte alone
        run(8'h43, 8'h90, 8'h01);
        chk(acc, 8'h6F);
        chk(mem.ram_q[8'h90], 8'h90);
        $display("t_addr done");
    endtask : t_addr
    task automatic t_ext;
        ld_acc(8'h5C);
        ld_side(16'h0100, 8'h00);
        run(8'hF0, 8'h00, 8'h00);
        ld_acc(8'h00);
        bank_sel <= 2'h0;
        run(8'hE2, 8'h00, 8'h00);
        chk(acc, 8'h5C);
        ld_acc(8'hA7);
        bank_sel <= 2'h3;
        run(8'hF2, 8'h00, 8'h00);
        ld_acc(8'h00);
        ld_side(16'h0098, 8'h00);
        run(8'hE0, 8'h00, 8'h00);
        chk(acc, 8'hA7);
        $display("t_ext done");
    endtask : t_ext
    task automatic t_alu;
        ld_side(16'h8002, 8'h03);
        ld_acc(8'h03);
        run(8'h93, 8'h00, 8'h00);
        chk(acc, 8'h85);
        ld_acc(8'h05);
        run(8'hA4, 8'h00, 8'h00);
        chk({b_reg, acc}, 16'h000F);
        run(8'h84, 8'h00, 8'h00);
        chk({7'h00, overflow, acc}, 16'h010F);
        ld_acc(8'h10);
        run(8'h94, 8'h01, 8'h00);
        chk(acc, 8'h0F);
        chk({aux_carry, overflow}, 16'h0002);
        run(8'h94, 8'h20, 8'h00);
        chk({carry, acc}, 16'h01EF);
        run(8'h94, 8'h01, 8'h00);
        chk(acc, 8'hED);
        $display("t_alu done");
    endtask : t_alu
    task automatic t_time;
        logic [15:0] tab [] = '{16'h2811, 16'h2612, 16'h2522, 16'h2422, 16'h3811, 16'h3612,
            16'h3522, 16'h3422, 16'h9811, 16'h9612, 16'h9522, 16'h9422, 16'h0411, 16'h0811,
            16'h0612, 16'h0522, 16'h1411, 16'h1811, 16'h1612, 16'h1522, 16'hA313, 16'hA419,
            16'h8419, 16'hD412, 16'hE411, 16'hF411, 16'hC411, 16'h2311, 16'h5811, 16'h5612,
            16'h5522, 16'h5422, 16'h5222, 16'h5333, 16'h4811, 16'h4612, 16'h4522, 16'h4422,
            16'h4222, 16'h4333, 16'h6811, 16'h6622, 16'h6522, 16'h6422, 16'h6222, 16'h6333,
            16'hE014, 16'hE214, 16'hF014, 16'hF214, 16'h9314, 16'hA511};
        foreach (tab[i]) begin
            run(tab[i][15:8], 8'h40, 8'h01);
            chk(16'(n_cyc), tab[i][3:0]);
            chk({retire_bytes, retire_cycles}, {tab[i][5:4], tab[i][3:0]});
            chk(ill, tab[i][15:8] == 8'hA5);
        end
        $display("t_time done");
    endtask : t_time
    initial begin
        {reset_n, issue_valid, data_pointer_load, b_load, bank_sel} = '0;
        {issue_opcode, issue_arg1, issue_arg2, b_value, data_pointer_value} = '0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_addr();
        t_ext();
        t_alu();
        t_time();
        end_of_test();
    end
    // Whole run is a few hundred cycles
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
endmodule : mat_core_tb

// >>> verif/mat_mem_model.sv
`timescale 1ns/1ns
module mat_mem_model (
    input  wire logic        clock,
    input  wire logic [7:0]  iram_addr,
    input  wire logic [7:0]  iram_wdata,
    input  wire logic        iram_we,
    output logic      [7:0]  iram_rdata,
    input  wire logic [7:0]  func_reg_addr,
    output logic      [7:0]  func_reg_rdata,
    input  wire logic [15:0] code_addr,
    output logic      [7:0]  code_rdata
);
    logic [7:0] ram_q [256];
    // Preset pattern so RAM and register hits read differently
    initial for (int i = 0; i < 256; i++) ram_q[i] = 8'(i * 17);
    always @(posedge clock) if (iram_we) ram_q[iram_addr] <= iram_wdata;
    assign iram_rdata     = ram_q[iram_addr];
    assign func_reg_rdata = ~func_reg_addr;
    assign code_rdata     = code_addr[15:8] ^ code_addr[7:0];
endmodule : mat_mem_model
